// ### hdl/ucmz_pkg.sv
/*
 Constants for the channel mode-zero configuration block: register
 address, field positions, reset values, command codes, thresholds.
 Assumes a host on the device parallel bus with a pointer command.
*/
// Behaviour
// [R1] Mode zero shares address zero; the set-pointer-to-zero command selects it.
// [R2] Bit 7 turns the receiver idle watchdog on or off.
// [R3] Enabled watchdog interrupts after 64 receiver bit periods without FIFO access.
// [R4] Watchdog expiry shows as character available in channel and interrupt status.
// [R5] Bit 6 is upper receiver level bit, paired with mode-one bit 6.
// [R6] Receive FIFO empty after reset; default level interrupts at one byte.
// [R7] Bits 5 and 4 pick the transmit empty-position interrupt level.
// [R8] Transmit FIFO reports all positions empty after reset, so requests once enabled.
// [R9] Level 00 requests only when transmit FIFO fully empty.
// [R10] Bit 3 picks FIFO depth: zero eight bytes, one sixteen bytes.
// [R11] Bits 2 to 0 pick rate group 000, 001 or 100 only.
// [R12] Receive thresholds 1,3,6,8 in eight mode; 1,8,12,16 in sixteen mode.
// [R13] Transmit thresholds 8,4,6,1 in eight mode; 16,8,12,1 in sixteen mode.
// [R14] Watchdog count restarts on FIFO read, runs only when enabled with data.
package ucmz_pkg;
  localparam logic [1:0] UCMZ_ADDR_MODE = 2'h0;
  localparam logic [3:0] UCMZ_CMD_PTR_ZERO = 4'hB;
  localparam logic [3:0] UCMZ_CMD_PTR_ONE = 4'h1;
  localparam int UCMZ_BIT_WDOG = 7;
  localparam int UCMZ_BIT_RXLVL = 6;
  localparam int UCMZ_BIT_TXLVL_HI = 5;
  localparam int UCMZ_BIT_TXLVL_LO = 4;
  localparam int UCMZ_BIT_DEPTH = 3;
  localparam int UCMZ_BIT_RATE_HI = 2;
  localparam int UCMZ_BIT_RATE_LO = 0;
  localparam logic [7:0] UCMZ_MODE0_RESET = 8'h00;
  localparam logic [7:0] UCMZ_MODE1_RESET = 8'h00;
  localparam logic [2:0] UCMZ_RATE_NORMAL = 3'h0;
  localparam logic [2:0] UCMZ_RATE_EXT1 = 3'h1;
  localparam logic [2:0] UCMZ_RATE_EXT2 = 3'h4;
  localparam logic [6:0] UCMZ_WDOG_BITS = 7'h40;
  localparam logic [4:0] UCMZ_DEPTH_8 = 5'h08;
  localparam logic [4:0] UCMZ_DEPTH_16 = 5'h10;
  typedef enum logic [1:0] {
    UCMZ_PTR_MODE_ZERO = 2'b00,
    UCMZ_PTR_MODE_ONE = 2'b01,
    UCMZ_PTR_MODE_TWO = 2'b10
  } ucmz_ptr_t;

  // Receive fill threshold: index {upper, lower}, depth bit
  function automatic logic [4:0] ucmz_rx_thr(input logic [1:0] sel, input logic deep);
    logic [4:0] t;
    t = 5'h01;
    case (sel)
      2'b00: t = 5'h01;
      2'b01: t = deep ? 5'h08 : 5'h03;
      2'b10: t = deep ? 5'h0C : 5'h06;
      2'b11: t = deep ? UCMZ_DEPTH_16 : UCMZ_DEPTH_8;
      default: t = 5'h01;
    endcase
    return t;
  endfunction : ucmz_rx_thr

  function automatic logic [4:0] ucmz_tx_thr(input logic [1:0] sel, input logic deep);
    logic [4:0] t;
    t = 5'h01;
    case (sel)
      2'b00: t = deep ? UCMZ_DEPTH_16 : UCMZ_DEPTH_8;
      2'b01: t = deep ? 5'h08 : 5'h04;
      2'b10: t = deep ? 5'h0C : 5'h06;
      2'b11: t = 5'h01;
      default: t = 5'h01;
    endcase
    return t;
  endfunction : ucmz_tx_thr
endpackage : ucmz_pkg

// ### hdl/ucmz_top.sv
/*
 Channel mode-zero configuration and interrupt level logic.
 Assumes the FIFO counts and bus strobes are synchronous to REF_CLK_I.
*/
module ucmz_top (
  input wire logic REF_CLK_I,
  input wire logic NRST_I,
  input wire logic [1:0] ADDR_I,
  input wire logic WR_I,
  input wire logic RD_I,
  input wire logic [7:0] WDATA_I,
  output logic [7:0] RDATA_O,
  input wire logic CMD_VALID_I,
  input wire logic [3:0] CMD_I,
  input wire logic [4:0] RX_COUNT_I,
  input wire logic [4:0] TX_COUNT_I,
  input wire logic RX_FIFO_READ_I,
  input wire logic RX_BIT_TICK_I,
  input wire logic TX_ENABLE_I,
  output logic RX_CHAR_AVAILABLE_O,
  output logic RX_INT_REQ_O,
  output logic TX_INT_REQ_O,
  output logic QUEUE_DEPTH_SELECT_O,
  output logic [2:0] RATE_GROUP_SELECT_O,
  output logic RATE_GROUP_ILLEGAL_O
);
  import ucmz_pkg::*;

  logic rst_meta_q;
  logic rst_n_q;
  logic [7:0] channel_a_mode_zero_q;
  logic [7:0] mode_register_one_q;
  ucmz_ptr_t ptr_q;
  logic access;
  logic deep;
  logic [4:0] rx_limit;
  logic [4:0] tx_free;
  logic [4:0] rx_thr;
  logic [4:0] tx_thr;
  logic wdog_expired;

  always_ff @(posedge REF_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      rst_meta_q <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n_q <= rst_meta_q;
    end
  end

  assign access = (WR_I || RD_I) && ADDR_I == UCMZ_ADDR_MODE;

  // Pointer: command steers address zero; each access walks to the next register, stopping at mode two
  always_ff @(posedge REF_CLK_I or negedge rst_n_q) begin
    if (!rst_n_q) begin
      ptr_q <= UCMZ_PTR_MODE_ONE;
    end else if (CMD_VALID_I && CMD_I == UCMZ_CMD_PTR_ZERO) begin
      ptr_q <= UCMZ_PTR_MODE_ZERO; // see [R1]
    end else if (CMD_VALID_I && CMD_I == UCMZ_CMD_PTR_ONE) begin
      ptr_q <= UCMZ_PTR_MODE_ONE;
    end else if (access) begin
      case (ptr_q)
        UCMZ_PTR_MODE_ZERO: ptr_q <= UCMZ_PTR_MODE_ONE;
        UCMZ_PTR_MODE_ONE: ptr_q <= UCMZ_PTR_MODE_TWO;
        UCMZ_PTR_MODE_TWO: ptr_q <= UCMZ_PTR_MODE_TWO;
        default: ptr_q <= UCMZ_PTR_MODE_ONE;
      endcase
    end
  end

  always_ff @(posedge REF_CLK_I or negedge rst_n_q) begin
    if (!rst_n_q) begin
      channel_a_mode_zero_q <= UCMZ_MODE0_RESET;
    end else if (WR_I && ADDR_I == UCMZ_ADDR_MODE && ptr_q == UCMZ_PTR_MODE_ZERO) begin
      channel_a_mode_zero_q <= WDATA_I; // see [R1]
    end
  end

  // Mode one kept only for its receiver level bit; rest belongs elsewhere
  always_ff @(posedge REF_CLK_I or negedge rst_n_q) begin
    if (!rst_n_q) begin
      mode_register_one_q <= UCMZ_MODE1_RESET;
    end else if (WR_I && ADDR_I == UCMZ_ADDR_MODE && ptr_q == UCMZ_PTR_MODE_ONE) begin
      mode_register_one_q <= WDATA_I;
    end
  end

  always_ff @(posedge REF_CLK_I or negedge rst_n_q) begin
    if (!rst_n_q) begin
      RDATA_O <= 8'h00;
    end else if (RD_I && ADDR_I == UCMZ_ADDR_MODE) begin
      case (ptr_q)
        UCMZ_PTR_MODE_ZERO: RDATA_O <= channel_a_mode_zero_q;
        UCMZ_PTR_MODE_ONE: RDATA_O <= mode_register_one_q;
        default: RDATA_O <= 8'h00;
      endcase
    end
  end

  assign deep = channel_a_mode_zero_q[UCMZ_BIT_DEPTH]; // see [R10]
  assign rx_limit = deep ? UCMZ_DEPTH_16 : UCMZ_DEPTH_8;
  // Counts at or above the selected 8- or 16-byte depth are clamped; the FIFO owner must honour depth
  assign tx_free = (TX_COUNT_I >= rx_limit) ? 5'h00 : rx_limit - TX_COUNT_I; // see [R8]
  assign rx_thr = ucmz_rx_thr({channel_a_mode_zero_q[UCMZ_BIT_RXLVL],
                               mode_register_one_q[UCMZ_BIT_RXLVL]}, deep); // see [R5] [R12]
  assign tx_thr = ucmz_tx_thr(channel_a_mode_zero_q[UCMZ_BIT_TXLVL_HI:UCMZ_BIT_TXLVL_LO],
                              deep); // see [R7] [R13]

  ucmz_wdog u_wdog (
    .clk_i(REF_CLK_I),
    .rst_n_i(rst_n_q),
    .enable_i(channel_a_mode_zero_q[UCMZ_BIT_WDOG]), // see [R2]
    .has_data_i(RX_COUNT_I != 5'h00),
    .fifo_read_i(RX_FIFO_READ_I),
    .bit_tick_i(RX_BIT_TICK_I),
    .expired_o(wdog_expired)
  );

  // Status bit tracks data presence, so an empty FIFO after reset reads zero
  always_ff @(posedge REF_CLK_I or negedge rst_n_q) begin
    if (!rst_n_q) begin
      RX_CHAR_AVAILABLE_O <= 1'b0;
      RX_INT_REQ_O <= 1'b0;
      TX_INT_REQ_O <= 1'b0;
    end else begin
      RX_CHAR_AVAILABLE_O <= (RX_COUNT_I != 5'h00); // see [R4] [R6]
      RX_INT_REQ_O <= (RX_COUNT_I >= rx_thr) || wdog_expired; // see [R3] [R4] [R6]
      TX_INT_REQ_O <= TX_ENABLE_I && (tx_free >= tx_thr); // see [R8] [R9]
    end
  end

  assign QUEUE_DEPTH_SELECT_O = deep;
  assign RATE_GROUP_SELECT_O = channel_a_mode_zero_q[UCMZ_BIT_RATE_HI:UCMZ_BIT_RATE_LO];
  assign RATE_GROUP_ILLEGAL_O = !(RATE_GROUP_SELECT_O == UCMZ_RATE_NORMAL ||
                                  RATE_GROUP_SELECT_O == UCMZ_RATE_EXT1 ||
                                  RATE_GROUP_SELECT_O == UCMZ_RATE_EXT2); // see [R11]

  sequence s_ptr_zero;
    CMD_VALID_I && CMD_I == UCMZ_CMD_PTR_ZERO;
  endsequence
  sequence s_write_mode;
    WR_I && ADDR_I == UCMZ_ADDR_MODE && !CMD_VALID_I;
  endsequence
  // Host leaves one quiet cycle between command and write
  sequence s_bus_idle;
    !WR_I && !RD_I && !CMD_VALID_I;
  endsequence
  property p_ptr_write;
    @(posedge REF_CLK_I) disable iff (!rst_n_q)
      s_ptr_zero ##1 s_bus_idle ##1 s_write_mode
      |=> channel_a_mode_zero_q == $past(WDATA_I);
  endproperty
  a_ptr_write: assert property (p_ptr_write) else $error("mode zero write lost"); // see [R1]

  property p_tx_empty_level;
    @(posedge REF_CLK_I) disable iff (!rst_n_q)
      TX_ENABLE_I && channel_a_mode_zero_q[5:4] == 2'b00 && TX_COUNT_I != 5'h00
      |=> !TX_INT_REQ_O;
  endproperty
  a_tx_empty_level: assert property (p_tx_empty_level) else $error("tx req with bytes"); // see [R9]

  property p_tx_empty_req;
    @(posedge REF_CLK_I) disable iff (!rst_n_q)
      TX_ENABLE_I && TX_COUNT_I == 5'h00 |=> TX_INT_REQ_O;
  endproperty
  a_tx_empty_req: assert property (p_tx_empty_req) else $error("tx empty no req"); // see [R8]

  property p_rx_default;
    @(posedge REF_CLK_I) disable iff (!rst_n_q)
      {channel_a_mode_zero_q[6], mode_register_one_q[6]} == 2'b00 && RX_COUNT_I != 5'h00
      |=> RX_INT_REQ_O;
  endproperty
  a_rx_default: assert property (p_rx_default) else $error("rx default level"); // see [R6]

  property p_rx_thr16;
    @(posedge REF_CLK_I) disable iff (!rst_n_q)
      deep && {channel_a_mode_zero_q[6], mode_register_one_q[6]} == 2'b10 &&
      RX_COUNT_I == 5'h0B && !wdog_expired |=> !RX_INT_REQ_O;
  endproperty
  a_rx_thr16: assert property (p_rx_thr16) else $error("rx 12 threshold"); // see [R12] [R5]

  property p_tx_thr8;
    @(posedge REF_CLK_I) disable iff (!rst_n_q)
      TX_ENABLE_I && !deep && channel_a_mode_zero_q[5:4] == 2'b01 && TX_COUNT_I == 5'h04
      |=> TX_INT_REQ_O;
  endproperty
  a_tx_thr8: assert property (p_tx_thr8) else $error("tx 4 threshold"); // see [R13] [R7]

  property p_wdog_int;
    @(posedge REF_CLK_I) disable iff (!rst_n_q)
      wdog_expired |=> RX_INT_REQ_O && RX_CHAR_AVAILABLE_O;
  endproperty
  a_wdog_int: assert property (p_wdog_int) else $error("watchdog not shown"); // see [R4] [R3]

  property p_depth;
    @(posedge REF_CLK_I) disable iff (!rst_n_q)
      QUEUE_DEPTH_SELECT_O == channel_a_mode_zero_q[3] && RATE_GROUP_ILLEGAL_O ==
      (RATE_GROUP_SELECT_O inside {3'h2, 3'h3, 3'h5, 3'h6, 3'h7});
  endproperty
  a_depth: assert property (p_depth) else $error("depth or rate decode"); // see [R10] [R11]

  sequence s_read_mode_zero;
    RD_I && ADDR_I == UCMZ_ADDR_MODE && ptr_q == UCMZ_PTR_MODE_ZERO;
  endsequence
  property p_read_mode_zero;
    @(posedge REF_CLK_I) disable iff (!rst_n_q)
      s_read_mode_zero |=> RDATA_O == $past(channel_a_mode_zero_q);
  endproperty
  a_read_mode_zero: assert property (p_read_mode_zero) else $error("mode zero read"); // see [R1]

  // Pointer parked past mode one must not touch mode zero
  sequence s_write_parked;
    WR_I && ADDR_I == UCMZ_ADDR_MODE && ptr_q == UCMZ_PTR_MODE_TWO;
  endsequence
  property p_write_refused;
    @(posedge REF_CLK_I) disable iff (!rst_n_q)
      s_write_parked |=> $stable(channel_a_mode_zero_q);
  endproperty
  a_write_refused: assert property (p_write_refused) else $error("parked write taken"); // see [R1]

  property p_wdog_quiet;
    @(posedge REF_CLK_I) disable iff (!rst_n_q)
      !channel_a_mode_zero_q[UCMZ_BIT_WDOG] |=> !wdog_expired;
  endproperty
  a_wdog_quiet: assert property (p_wdog_quiet) else $error("watchdog while disabled"); // see [R2]

  property p_rx_thr8;
    @(posedge REF_CLK_I) disable iff (!rst_n_q)
      !deep && {channel_a_mode_zero_q[6], mode_register_one_q[6]} == 2'b01 &&
      RX_COUNT_I == 5'h02 && !wdog_expired |=> !RX_INT_REQ_O;
  endproperty
  a_rx_thr8: assert property (p_rx_thr8) else $error("rx 3 threshold"); // see [R12] [R5]
endmodule : ucmz_top

// ### hdl/ucmz_wdog.sv
/*
 Receiver idle watchdog: counts receiver 1x bit ticks with no FIFO read.
 Assumes the tick is a one-cycle pulse synchronous to the device clock.
*/
module ucmz_wdog (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic enable_i,
  input wire logic has_data_i,
  input wire logic fifo_read_i,
  input wire logic bit_tick_i,
  output logic expired_o
);
  import ucmz_pkg::*;
  logic [6:0] count_q;

  // Count held at limit so expiry stays up until the FIFO is read or emptied, or the watchdog is disabled
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      count_q <= 7'h00;
    end else if (fifo_read_i || !enable_i || !has_data_i) begin
      count_q <= 7'h00; // see [R14]
    end else if (bit_tick_i && count_q != UCMZ_WDOG_BITS) begin
      count_q <= count_q + 7'h01; // see [R3]
    end
  end

  assign expired_o = (count_q == UCMZ_WDOG_BITS);

  property p_wdog_clear;
    @(posedge clk_i) disable iff (!rst_n_i) fifo_read_i |=> !expired_o;
  endproperty
  a_wdog_clear: assert property (p_wdog_clear) else $error("watchdog not cleared by read"); // see [R14]

  property p_wdog_off;
    @(posedge clk_i) disable iff (!rst_n_i) !enable_i |=> count_q == 7'h00;
  endproperty
  a_wdog_off: assert property (p_wdog_off) else $error("watchdog ran while disabled"); // see [R2]
endmodule : ucmz_wdog

// ### verification/tb_top.sv
/*
 Self-checking bench for the mode-zero block and its watchdog.
 Assumes the host model file and the design package are compiled first.
*/
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import ucmz_pkg::*;
  logic ref_clk = 1'b0;
  logic nrst = 1'b0;
  logic [1:0] addr;
  logic wr, rd, cmd_valid, rx_read, tick, tx_en;
  logic [7:0] wdata, rdata, v;
  logic [3:0] cmd;
  logic [4:0] rx_count, tx_count, dep;
  logic char_avail, rx_int, tx_int, depth_sel, rate_bad;
  logic [2:0] rate_sel;
  logic [1:0] sel;
  int failures = 0;
  int total_checks = 0;
  logic [2:0] rates [3] = '{UCMZ_RATE_NORMAL, UCMZ_RATE_EXT1, UCMZ_RATE_EXT2};
  logic [4:0] rx_thr [2][4] = '{'{5'h01, 5'h03, 5'h06, 5'h08}, '{5'h01, 5'h08, 5'h0C, 5'h10}};
  logic [4:0] tx_thr [2][4] = '{'{5'h08, 5'h04, 5'h06, 5'h01}, '{5'h10, 5'h08, 5'h0C, 5'h01}};
  always #2 ref_clk = ~ref_clk;
  ucmz_host_model host (.clk_i(ref_clk), .addr_o(addr), .wr_o(wr), .rd_o(rd),
    .wdata_o(wdata), .cmd_valid_o(cmd_valid), .cmd_o(cmd), .rdata_i(rdata));
  ucmz_top dut (.REF_CLK_I(ref_clk), .NRST_I(nrst), .ADDR_I(addr), .WR_I(wr), .RD_I(rd),
    .WDATA_I(wdata), .RDATA_O(rdata), .CMD_VALID_I(cmd_valid), .CMD_I(cmd),
    .RX_COUNT_I(rx_count), .TX_COUNT_I(tx_count), .RX_FIFO_READ_I(rx_read),
    .RX_BIT_TICK_I(tick), .TX_ENABLE_I(tx_en), .RX_CHAR_AVAILABLE_O(char_avail),
    .RX_INT_REQ_O(rx_int), .TX_INT_REQ_O(tx_int), .QUEUE_DEPTH_SELECT_O(depth_sel),
    .RATE_GROUP_SELECT_O(rate_sel), .RATE_GROUP_ILLEGAL_O(rate_bad));
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic settle(input int n);
    repeat (n) @(negedge ref_clk);
  endtask : settle
  // Ticks spaced apart so each one is a clean single pulse
  task automatic ticks(input int n);
    repeat (n) begin
      @(negedge ref_clk);
      tick = 1'b1;
      @(negedge ref_clk);
      tick = 1'b0;
    end
    settle(3);
  endtask : ticks
  task automatic summarize;
    $display("Checks %0d, mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : summarize
  initial begin
    #40000;
    failures++;
    summarize();
  end
  initial begin
    rx_count = 5'h00;
    tx_count = 5'h00;
    rx_read = 1'b0;
    tick = 1'b0;
    tx_en = 1'b0;
    repeat (12) @(posedge ref_clk);
    @(negedge ref_clk);
    nrst = 1'b1;
    settle(3);
    host.pulse_cmd(UCMZ_CMD_PTR_ZERO);
    host.read_mode(v);
    check(v, 8'h00);
    check(rx_int, 1'b0);
    check(tx_int, 1'b0);
    tx_en = 1'b1;
    settle(2);
    check(tx_int, 1'b1);
    $display("Test reset done");
    foreach (rates[i]) begin
      host.set_regs({4'h1, 1'b1, rates[i]}, 8'h00);
      host.pulse_cmd(UCMZ_CMD_PTR_ZERO);
      host.read_mode(v);
      check(v, {4'h1, 1'b1, rates[i]});
      check(depth_sel, 1'b1);
      check(rate_sel, rates[i]);
      check(rate_bad, 1'b0);
    end
    $display("Test rate groups done");
    for (int d = 0; d < 2; d++) begin
      for (int s = 0; s < 4; s++) begin
        sel = s[1:0];
        dep = (d == 1) ? 5'h10 : 5'h08;
        host.set_regs({1'b0, sel[1], sel, d[0], 3'h0}, {1'b0, sel[0], 6'h00});
        rx_count = rx_thr[d][s] - 5'h01;
        tx_count = dep - tx_thr[d][s] + 5'h01;
        settle(2);
        check(rx_int, 1'b0);
        check(tx_int, 1'b0);
        rx_count = rx_thr[d][s];
        tx_count = dep - tx_thr[d][s];
        settle(2);
        check(rx_int, 1'b1);
        check(tx_int, 1'b1);
        check(char_avail, 1'b1);
        check(depth_sel, d[0]);
      end
    end
    $display("Test thresholds done");
    // Level 11 deep needs 16 bytes, so only the watchdog can interrupt
    host.set_regs(8'hC8, 8'h40);
    rx_count = 5'h01;
    ticks(63);
    check(rx_int, 1'b0);
    ticks(1);
    check(rx_int, 1'b1);
    check(char_avail, 1'b1);
    @(negedge ref_clk);
    rx_read = 1'b1;
    @(negedge ref_clk);
    rx_read = 1'b0;
    settle(2);
    check(rx_int, 1'b0);
    ticks(63);
    check(rx_int, 1'b0);
    rx_count = 5'h00;
    ticks(64);
    check(rx_int, 1'b0);
    host.set_regs(8'h48, 8'h40);
    rx_count = 5'h01;
    ticks(70);
    check(rx_int, 1'b0);
    $display("Test watchdog done");
    // Mode-one pointer command, then a write once the pointer is parked
    host.pulse_cmd(UCMZ_CMD_PTR_ONE);
    host.read_mode(v);
    check(v, 8'h40);
    host.write_mode(8'h89);
    host.pulse_cmd(UCMZ_CMD_PTR_ZERO);
    host.read_mode(v);
    check(v, 8'h48);
    check(rate_sel, UCMZ_RATE_NORMAL);
    $display("Test pointer done");
    summarize();
  end
endmodule : tb_top

// ### verification/ucmz_host_model.sv
/*
 Host processor model: issues pointer commands and mode register
 accesses. Assumes the bench clock and that bus inputs move at negedge.
*/
module ucmz_host_model (
  input wire logic clk_i,
  output logic [1:0] addr_o,
  output logic wr_o,
  output logic rd_o,
  output logic [7:0] wdata_o,
  output logic cmd_valid_o,
  output logic [3:0] cmd_o,
  input wire logic [7:0] rdata_i
);
  timeunit 1ns;
  timeprecision 1ps;
  import ucmz_pkg::*;
  initial begin
    addr_o = UCMZ_ADDR_MODE;
    wr_o = 1'b0;
    rd_o = 1'b0;
    wdata_o = 8'h00;
    cmd_valid_o = 1'b0;
    cmd_o = 4'h0;
  end
  // Released lines flip so a stale value never looks valid
  task automatic pulse_cmd(input logic [3:0] c);
    @(negedge clk_i);
    cmd_o = c;
    cmd_valid_o = 1'b1;
    @(negedge clk_i);
    cmd_valid_o = 1'b0;
    cmd_o = ~c;
  endtask : pulse_cmd
  task automatic write_mode(input logic [7:0] d);
    @(negedge clk_i);
    wdata_o = d;
    wr_o = 1'b1;
    @(negedge clk_i);
    wr_o = 1'b0;
    wdata_o = ~d;
  endtask : write_mode
  task automatic read_mode(output logic [7:0] d);
    @(negedge clk_i);
    rd_o = 1'b1;
    @(negedge clk_i);
    rd_o = 1'b0;
    @(negedge clk_i);
    d = rdata_i;
  endtask : read_mode
  // Pointer walks to mode one after the first write
  task automatic set_regs(input logic [7:0] m0, input logic [7:0] m1);
    pulse_cmd(UCMZ_CMD_PTR_ZERO);
    write_mode(m0);
    write_mode(m1);
  endtask : set_regs
endmodule : ucmz_host_model
